// *** rtl/rmb_defines.svh ***
// Register offsets, field positions and reset values of the register bank
`ifndef RMB_DEFINES_SVH
`define RMB_DEFINES_SVH

`define RMB_OP_BLOCK_WRITE   8'h28
`define RMB_MAX_OFFSET       5'h12
`define RMB_MAP_DEPTH        19
`define RMB_MAPPED_MASK      19'h72abf
`define RMB_WRITABLE_MASK    19'h70abf

`define RMB_OFS_STATUS       5'h00
`define RMB_OFS_GLOBAL       5'h01
`define RMB_OFS_FORMAT       5'h02
`define RMB_OFS_AVERAGING    5'h03
`define RMB_OFS_CONV_MODE    5'h04
`define RMB_OFS_PIN_FUNC     5'h05
`define RMB_OFS_DIRECTION    5'h07
`define RMB_OFS_DRIVE        5'h09
`define RMB_OFS_OUT_LEVEL    5'h0b
`define RMB_OFS_IN_LEVEL     5'h0d
`define RMB_OFS_SEQ_CFG      5'h10
`define RMB_OFS_MAN_CHAN     5'h11
`define RMB_OFS_SCAN_EN      5'h12

`define RMB_STATUS_RESET     8'h80
`define RMB_REG_RESET        8'h00
`define RMB_BIT_FIXED_ONE    7
`define RMB_BIT_SEQ_RUN      6
`define RMB_BIT_HIGH_SPEED   5
`define RMB_BIT_AVG_DONE     3
`define RMB_BIT_FUSE_ERR     2
`define RMB_BIT_BROWNOUT     0

`endif

// *** rtl/rmb_pkg.sv ***
// Types shared by the register bank and its bench
package rmb_pkg;

   typedef enum logic [2:0] {
      RMB_IDLE   = 3'b000,
      RMB_OPCODE = 3'b001,
      RMB_ADDR   = 3'b010,
      RMB_DATA   = 3'b011,
      RMB_SKIP   = 3'b100
   } rmb_state_t;

   typedef struct packed {
      logic       frameStart;   // Start or repeated start, device addressed for write
      logic       frameStop;    // Stop condition
      logic       byteValid;    // One received byte
      logic [7:0] byteData;
   } rmb_link_t;

   typedef struct packed {
      logic seqRunning;
      logic highSpeed;
      logic fuseErr;
      logic avgDoneEvent;
      logic brownoutEvent;
   } rmb_events_t;

   typedef struct packed {
      logic [7:0] deviceStatus;
      logic [7:0] globalControl;
      logic [7:0] outputFormatConfig;
      logic [7:0] averagingConfig;
      logic [7:0] conversionModeConfig;
      logic [7:0] pinFunctionConfig;
      logic [7:0] digitalDirectionConfig;
      logic [7:0] outputDriveConfig;
      logic [7:0] outputLevel;
      logic [7:0] inputLevel;
      logic [7:0] sequencerConfig;
      logic [7:0] manualChannelSelect;
      logic [7:0] scanChannelEnable;
   } rmb_regs_t;

endpackage : rmb_pkg

// *** rtl/rmb_register_bank.sv ***
// Byte-wide register map with block-write handling from the serial link
//
// Contract
// - Opcode, start address, then bytes ascending addresses
// - Unmapped address bytes dropped, pointer still advances
// - Bytes past highest offset are ignored
// - Decode thirteen listed offsets, highest 0x12
// - Status register resets to 0x80
// - All other registers reset to zero
// - Status bit layout, reserved bits read zero
// - Opcode 0x28 selects block write
// - Writing one clears averaging-done flag
// - Brown-out flag set by event, cleared by one
`timescale 1ns/10ps
`include "rmb_defines.svh"

module rmb_register_bank (
   input  wire logic                clk,        // 100 MHz clock
   input  wire logic                nrst,       // Synchronous reset, active low
   input  wire rmb_pkg::rmb_link_t  link,       // Byte-level events from the serial front end
   input  wire rmb_pkg::rmb_events_t events,    // Status sources from the converter core
   input  wire logic [7:0]          pinLevel,   // Sampled digital input levels
   output rmb_pkg::rmb_regs_t       regs,       // Register contents
   output rmb_pkg::rmb_state_t      state       // Write decoder state
);
   import rmb_pkg::*;

   localparam int DEPTH = `RMB_MAP_DEPTH;
   localparam logic [DEPTH-1:0] MAPPED   = `RMB_MAPPED_MASK;
   localparam logic [DEPTH-1:0] WRITABLE = `RMB_WRITABLE_MASK;

   rmb_state_t state_reg;
   logic [7:0] ptr_reg;
   logic [7:0] cfg_reg [DEPTH];
   logic [7:0] status_reg;
   logic [7:0] inLevel_reg;
   logic       dataWrite;
   logic       inMap;

   // ---------------------------------------------------------------
   // Write decoder
   // ---------------------------------------------------------------
   assign inMap     = (ptr_reg <= {3'h0, `RMB_MAX_OFFSET});
   assign dataWrite = (state_reg == RMB_DATA) && link.byteValid && !link.frameStart && !link.frameStop;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= RMB_IDLE;
      end else if (link.frameStart) begin
         state_reg <= RMB_OPCODE;
      end else if (link.frameStop) begin
         state_reg <= RMB_IDLE;
      end else if (link.byteValid) begin
         case (state_reg)
            RMB_OPCODE: begin
               if (link.byteData == `RMB_OP_BLOCK_WRITE) begin
                  state_reg <= RMB_ADDR;
               end else begin
                  state_reg <= RMB_SKIP;
               end
            end
            RMB_ADDR: begin
               state_reg <= RMB_DATA;
            end
            RMB_DATA: begin
               state_reg <= RMB_DATA;
            end
            RMB_SKIP: begin
               state_reg <= RMB_SKIP;
            end
            default: begin
               state_reg <= RMB_IDLE;
            end
         endcase
      end
   end

   // Pointer parks past the map so a long burst cannot wrap back into it
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ptr_reg <= 8'h00;
      end else if (state_reg == RMB_ADDR && link.byteValid && !link.frameStart && !link.frameStop) begin
         ptr_reg <= link.byteData;
      end else if (dataWrite && inMap) begin
         ptr_reg <= ptr_reg + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 1; g < DEPTH; g++) begin : gCfg
         if (WRITABLE[g]) begin : gRw
            always_ff @(posedge clk) begin
               if (!nrst) begin
                  cfg_reg[g] <= `RMB_REG_RESET;
               end else if (dataWrite && inMap && ptr_reg[4:0] == 5'(g)) begin
                  cfg_reg[g] <= link.byteData;
               end
            end
         end else begin : gNone
            always_ff @(posedge clk) begin
               cfg_reg[g] <= `RMB_REG_RESET;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      cfg_reg[0] <= `RMB_REG_RESET;
   end

   // Read-only input levels, never touched by the write path
   always_ff @(posedge clk) begin
      if (!nrst) begin
         inLevel_reg <= `RMB_REG_RESET;
      end else begin
         inLevel_reg <= pinLevel;
      end
   end

   // ---------------------------------------------------------------
   // Status register
   // ---------------------------------------------------------------
   logic statusWrite;
   assign statusWrite = dataWrite && ptr_reg == {3'h0, `RMB_OFS_STATUS};

   always_ff @(posedge clk) begin
      if (!nrst) begin
         status_reg <= `RMB_STATUS_RESET;
      end else begin
         status_reg[7:4] <= {1'b1, events.seqRunning, events.highSpeed, 1'b0};
         status_reg[2:1] <= {events.fuseErr, 1'b0};
         // Set wins over a clear in the same cycle so no event is lost
         if (events.avgDoneEvent) begin
            status_reg[`RMB_BIT_AVG_DONE] <= 1'b1;
         end else if (statusWrite && link.byteData[`RMB_BIT_AVG_DONE]) begin
            status_reg[`RMB_BIT_AVG_DONE] <= 1'b0;
         end
         if (events.brownoutEvent) begin
            status_reg[`RMB_BIT_BROWNOUT] <= 1'b1;
         end else if (statusWrite && link.byteData[`RMB_BIT_BROWNOUT]) begin
            status_reg[`RMB_BIT_BROWNOUT] <= 1'b0;
         end
      end
   end

   assign state = state_reg;
   assign regs  = '{
      deviceStatus:           status_reg,
      globalControl:          cfg_reg[`RMB_OFS_GLOBAL],
      outputFormatConfig:     cfg_reg[`RMB_OFS_FORMAT],
      averagingConfig:        cfg_reg[`RMB_OFS_AVERAGING],
      conversionModeConfig:   cfg_reg[`RMB_OFS_CONV_MODE],
      pinFunctionConfig:      cfg_reg[`RMB_OFS_PIN_FUNC],
      digitalDirectionConfig: cfg_reg[`RMB_OFS_DIRECTION],
      outputDriveConfig:      cfg_reg[`RMB_OFS_DRIVE],
      outputLevel:            cfg_reg[`RMB_OFS_OUT_LEVEL],
      inputLevel:             inLevel_reg,
      sequencerConfig:        cfg_reg[`RMB_OFS_SEQ_CFG],
      manualChannelSelect:    cfg_reg[`RMB_OFS_MAN_CHAN],
      scanChannelEnable:      cfg_reg[`RMB_OFS_SCAN_EN]
   };

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence sOpcode;
      state_reg == RMB_OPCODE && link.byteValid && link.byteData == `RMB_OP_BLOCK_WRITE
         && !link.frameStart && !link.frameStop;
   endsequence

   a_opcode_accept: assert property (@(posedge clk) disable iff (!nrst)
      sOpcode |=> state_reg == RMB_ADDR) else $error("block write opcode not accepted");

   a_ptr_advance: assert property (@(posedge clk) disable iff (!nrst)
      dataWrite && inMap |=> ptr_reg == $past(ptr_reg) + 8'h01) else $error("pointer did not advance");

   a_beyond_ignored: assert property (@(posedge clk) disable iff (!nrst)
      dataWrite && !inMap |=> $stable(ptr_reg) && $stable(regs.scanChannelEnable))
      else $error("byte past map changed state");

   a_hole_dropped: assert property (@(posedge clk) disable iff (!nrst)
      dataWrite && ptr_reg == 8'h06 |=> $stable(regs.pinFunctionConfig) && $stable(regs.digitalDirectionConfig)
         && ptr_reg == 8'h07) else $error("unmapped byte not dropped");

   a_stop_idle: assert property (@(posedge clk) disable iff (!nrst)
      link.frameStop && !link.frameStart |=> state_reg == RMB_IDLE) else $error("stop did not end write");

   a_status_reset: assert property (@(posedge clk)
      !nrst |=> regs.deviceStatus == `RMB_STATUS_RESET && regs.globalControl == `RMB_REG_RESET)
      else $error("reset values wrong");

   a_status_layout: assert property (@(posedge clk) disable iff (!nrst)
      ##1 regs.deviceStatus[7] && !regs.deviceStatus[4] && !regs.deviceStatus[1]
         && regs.deviceStatus[6] == $past(events.seqRunning)) else $error("status layout wrong");

   a_avg_clear: assert property (@(posedge clk) disable iff (!nrst)
      statusWrite && link.byteData[3] && !events.avgDoneEvent |=> !regs.deviceStatus[3])
      else $error("averaging flag not cleared");

   a_brownout_set: assert property (@(posedge clk) disable iff (!nrst)
      events.brownoutEvent |=> regs.deviceStatus[0]) else $error("brown-out flag not set");

   a_ro_kept: assert property (@(posedge clk) disable iff (!nrst)
      statusWrite |=> regs.deviceStatus[2] == $past(events.fuseErr)) else $error("read-only bit written");

   a_reg_store: assert property (@(posedge clk) disable iff (!nrst)
      dataWrite && ptr_reg == 8'h12 |=> regs.scanChannelEnable == $past(link.byteData))
      else $error("highest offset not stored");

   a_hole_any: assert property (@(posedge clk) disable iff (!nrst)
      dataWrite && inMap && !MAPPED[ptr_reg[4:0]] |=> ptr_reg == $past(ptr_reg) + 8'h01
         && $stable(regs[95:32]) && $stable(regs[23:0])) else $error("hole byte changed a register");

   a_opcode_reject: assert property (@(posedge clk) disable iff (!nrst)
      state_reg == RMB_OPCODE && link.byteValid && link.byteData != `RMB_OP_BLOCK_WRITE
         && !link.frameStart && !link.frameStop |=> state_reg == RMB_SKIP)
      else $error("foreign opcode not skipped");

   // Event and clear in one cycle: the event must survive
   a_flag_set_wins: assert property (@(posedge clk) disable iff (!nrst)
      statusWrite && events.avgDoneEvent && events.brownoutEvent |=> regs.deviceStatus[3] && regs.deviceStatus[0])
      else $error("flag set lost to clear");

endmodule : rmb_register_bank

// *** tb/rmb_host_model.sv ***
// Byte-level host model driving the serial link events
`timescale 1ns/10ps
module rmb_host_model (
   input  logic               clk,  // Device clock
   output rmb_pkg::rmb_link_t link  // Byte events towards the device
);
   import rmb_pkg::*;
   initial link = '0;
   task automatic drive(input logic s, input logic p, input logic v, input logic [7:0] d);
      @(posedge clk);
      link <= '{s, p, v, d};
   endtask : drive
   task automatic start();
      drive(1'b1, 1'b0, 1'b0, ~link.byteData);
   endtask : start
   task automatic stop();
      drive(1'b0, 1'b1, 1'b0, ~link.byteData);
   endtask : stop
   task automatic put(input logic [7:0] d);
      drive(1'b0, 1'b0, 1'b1, d);
   endtask : put
   // Released data line shows the inverse, never a stale byte
   task automatic idle();
      drive(1'b0, 1'b0, 1'b0, ~link.byteData);
   endtask : idle
endmodule : rmb_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for the register bank block-write path
`timescale 1ns/10ps
module tb_top;
   import rmb_pkg::*;
   localparam logic [7:0] OFS [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07,
                                       8'h09, 8'h0b, 8'h0d, 8'h10, 8'h11, 8'h12};
   logic         clk;
   logic         nrst;
   rmb_link_t    link;
   rmb_events_t  events;
   logic [7:0]   pinLevel;
   rmb_regs_t    regs;
   rmb_state_t   state;
   logic [103:0] expv;
   int           error_cnt = 0;
   int           cmp_count = 0;
   int           cycles = 0;

   rmb_register_bank dut (.clk(clk), .nrst(nrst), .link(link), .events(events),
                          .pinLevel(pinLevel), .regs(regs), .state(state));
   rmb_host_model host (.clk(clk), .link(link));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, far above the roughly 140 cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         error_cnt++;
         $display("ERROR t=%0t timeout", $time);
         summarize();
      end
   end

   function automatic int slot(input logic [7:0] a);
      slot = -1;
      for (int k = 0; k < 13; k++)
         if (OFS[k] == a) slot = k;
   endfunction : slot

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic chk(input logic [103:0] got, input logic [103:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t regs %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chkState(input rmb_state_t got, input rmb_state_t exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t state %0d exp %0d", $time, got, exp);
      end
   endtask : chkState

   task automatic blockWrite(input logic [7:0] op, input logic [7:0] a0, input logic [7:0] d0, input int n);
      logic [7:0] a;
      logic [7:0] d;
      int         k;
      host.start();
      host.put(op);
      host.put(a0);
      for (int i = 0; i < n; i++) begin
         a = a0 + i[7:0];
         d = d0 + i[7:0];
         k = slot(a);
         host.put(d);
         if (op == 8'h28 && a == 8'h00) begin
            expv[99] = expv[99] & ~d[3];
            expv[96] = expv[96] & ~d[0];
         end else if (op == 8'h28 && k > 0 && a != 8'h0d) begin
            expv[103-8*k -: 8] = d;
         end
      end
      host.stop();
      host.idle();
      settle(2);
      chkState(state, RMB_IDLE);
   endtask : blockWrite

   task automatic testReset();
      settle(2);
      chk(regs, expv);
      $display("reset values done");
   endtask : testReset

   task automatic testSweep();
      @(posedge clk);
      pinLevel <= 8'h5a;
      expv[103-8*9 -: 8] = 8'h5a;
      blockWrite(8'h28, 8'h00, 8'h30, 22);
      chk(regs, expv);
      @(posedge clk);
      pinLevel <= 8'ha5;
      expv[103-8*9 -: 8] = 8'ha5;
      host.put(8'h77);
      host.idle();
      settle(2);
      chk(regs, expv);
      $display("sweep done");
   endtask : testSweep

   task automatic testBadOpcode();
      blockWrite(8'h08, 8'h01, 8'hc0, 3);
      chk(regs, expv);
      $display("bad opcode done");
   endtask : testBadOpcode

   task automatic testStatus();
      @(posedge clk);
      events <= 5'b11111;
      @(posedge clk);
      events <= 5'b11100;
      expv[103:96] = 8'hed;
      settle(2);
      chk(regs, expv);
      blockWrite(8'h28, 8'h00, 8'h00, 1);
      chk(regs, expv);
      blockWrite(8'h28, 8'h00, 8'h08, 1);
      chk(regs, expv);
      blockWrite(8'h28, 8'h00, 8'h01, 1);
      chk(regs, expv);
      host.start();
      host.put(8'h28);
      host.put(8'h00);
      host.put(8'h09);
      events <= 5'b11111;
      host.stop();
      events <= 5'b11100;
      host.idle();
      expv[103:96] = 8'hed;
      settle(2);
      chk(regs, expv);
      @(posedge clk);
      events <= 5'b00000;
      expv[103:96] = 8'h89;
      blockWrite(8'h28, 8'h00, 8'h09, 1);
      chk(regs, expv);
      $display("status done");
   endtask : testStatus

   task automatic testRestart();
      host.start();
      host.put(8'h28);
      host.put(8'h02);
      host.put(8'ha1);
      host.start();
      host.put(8'h08);
      host.put(8'h03);
      host.put(8'hb2);
      host.stop();
      @(negedge clk);
      chkState(state, RMB_SKIP);
      host.idle();
      expv[103-8*2 -: 8] = 8'ha1;
      settle(2);
      chk(regs, expv);
      $display("restart done");
   endtask : testRestart

   task automatic testMidReset();
      @(posedge clk);
      nrst <= 1'b0;
      settle(2);
      chk(regs, {8'h80, 96'h0});
      @(posedge clk);
      nrst <= 1'b1;
      expv = {8'h80, 64'h0, 8'ha5, 24'h0};
      settle(2);
      chk(regs, expv);
      blockWrite(8'h28, 8'h10, 8'h3c, 3);
      chk(regs, expv);
      $display("mid reset done");
   endtask : testMidReset

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   initial begin
      nrst = 1'b0;
      events = '0;
      pinLevel = 8'h00;
      expv = {8'h80, 96'h0};
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      testReset();
      testSweep();
      testBadOpcode();
      testStatus();
      testRestart();
      testMidReset();
      summarize();
   end
endmodule : tb_top
